// file: testbench.sv
`timescale 1ns/1ps
`include "tioec_regs.vh"
// ----------------------------------------------------------------
// bench
// ----------------------------------------------------------------
module testbench;
    reg clk_sys = 1'h0, rst = 1'h1, wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
    reg [31:0] wb_adr_i = 32'h0, wb_dat_i = 32'h0, q;
    reg [3:0] wb_sel_i = 4'h0;
    reg timer_run_enable = 1'h0, external_event_clock_select = 1'h0;
    reg compare_match0 = 1'h0, compare_match1 = 1'h0, counter_wrap = 1'h0;
    reg [2:0] timer_mode = 3'h0;
    wire [31:0] wb_dat_o;
    wire wb_ack_o, timer_in_pin0, timer_in_pin1, timer_out_pin0, timer_out_pin1;
    wire capture0_strobe, capture1_strobe, event_count_strobe, trigger_strobe;
    wire overflow_interrupt, ccr0_capture_mode, ccr1_capture_mode;
    int err_total = 0, cmp_count = 0, cycles = 0, n_c0 = 0, n_c1 = 0, n_ev = 0, n_tr = 0;
    int n_ov = 0, b;
    logic [27:0] ix [4] = '{`TIOEC_IDX_OUT_CTRL, `TIOEC_IDX_CAP_EDGE, `TIOEC_IDX_EVT_TRIG,
        `TIOEC_IDX_CC_OPT};
    logic [7:0] mk [4] = '{`TIOEC_MASK_OUT_CTRL, `TIOEC_MASK_CAP_EDGE, `TIOEC_MASK_EVT_TRIG,
        8'h30};
    always #4 clk_sys = ~clk_sys;
    tioec_top u_dut (.clk_sys, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
        .wb_dat_i, .wb_dat_o, .wb_ack_o, .timer_run_enable, .external_event_clock_select,
        .timer_mode, .compare_match0, .compare_match1, .counter_wrap, .timer_in_pin0,
        .timer_in_pin1, .timer_out_pin0, .timer_out_pin1, .capture0_strobe, .capture1_strobe,
        .event_count_strobe, .trigger_strobe, .overflow_interrupt, .ccr0_capture_mode,
        .ccr1_capture_mode);
    tioec_pin_model u_pins (.clk_sys, .timer_in_pin0, .timer_in_pin1);
    always @(posedge clk_sys) begin
        n_c0 <= n_c0 + (capture0_strobe === 1'h1);
        n_c1 <= n_c1 + (capture1_strobe === 1'h1);
        n_ev <= n_ev + (event_count_strobe === 1'h1);
        n_tr <= n_tr + (trigger_strobe === 1'h1);
        n_ov <= n_ov + (overflow_interrupt === 1'h1);
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_total++;
            end_of_test;
        end
    end
    task end_of_test;
        $display("mismatches %0d, comparisons %0d", err_total, cmp_count);
        if (err_total == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task chk2(input logic a, input logic c, input logic [1:0] e);
        chk({30'h0, a, c}, {30'h0, e});
    endtask
    task idle(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task wb(input logic we, input logic s, input logic [27:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        wb_cyc_i <= 1'h1;
        wb_stb_i <= 1'h1;
        wb_we_i <= we;
        wb_sel_i <= {3'h0, s};
        wb_adr_i <= {2'h0, a, 2'h0};
        wb_dat_i <= {24'h0, d};
        @(posedge clk_sys);
        while (wb_ack_o !== 1'h1) @(posedge clk_sys);
        q = wb_dat_o;
        wb_cyc_i <= 1'h0;
        wb_stb_i <= 1'h0;
        @(posedge clk_sys);
    endtask
    task wr(input logic [27:0] a, input logic [7:0] d);
        wb(1'h1, 1'h1, a, d);
    endtask
    task rd(input logic [27:0] a, input logic [7:0] e);
        wb(1'h0, 1'h1, a, 8'h00);
        chk(q, {24'h0, e});
    endtask
    task run(input logic r);
        @(posedge clk_sys);
        timer_run_enable <= r;
    endtask
    task cfg(input logic [2:0] m, input logic e);
        run(1'h0);
        timer_mode <= m;
        external_event_clock_select <= e;
    endtask
    task strobe(input int w);
        @(posedge clk_sys);
        compare_match0 <= w == 0;
        compare_match1 <= w == 1;
        counter_wrap <= w == 2;
        @(posedge clk_sys);
        {compare_match0, compare_match1, counter_wrap} <= 3'h0;
        idle(2);
    endtask
    task edges(input int pin, input int gap, input int e0, e1, ev, tr);
        int b0, b1, b2, b3;
        b0 = n_c0;
        b1 = n_c1;
        b2 = n_ev;
        b3 = n_tr;
        u_pins.pulse(pin, gap);
        chk(n_c0 - b0, e0);
        chk(n_c1 - b1, e1);
        chk(n_ev - b2, ev);
        chk(n_tr - b3, tr);
    endtask
    task t_regs;
        for (int i = 0; i < 4; i++) begin
            rd(ix[i], 8'h00);
            wb(1'h1, 1'h0, ix[i], 8'hFF);
            rd(ix[i], 8'h00);
            wr(ix[i], 8'hFF);
            rd(ix[i], mk[i]);
            wr(ix[i], 8'h00);
        end
        wr(28'h0000100, 8'hFF);
        rd(28'h0000100, 8'h00);
    endtask
    task t_out;
        wr(ix[0], 8'h08);
        idle(2);
        chk2(timer_out_pin1, timer_out_pin0, 2'h2);
        wr(ix[0], 8'h02);
        idle(2);
        chk2(timer_out_pin1, timer_out_pin0, 2'h1);
        wr(ix[0], 8'h05);
        idle(2);
        chk2(timer_out_pin1, timer_out_pin0, 2'h3);
        run(1'h1);
        strobe(0);
        chk2(timer_out_pin1, timer_out_pin0, 2'h2);
        strobe(1);
        chk2(timer_out_pin1, timer_out_pin0, 2'h0);
        run(1'h0);
        wr(ix[0], 8'h0F);
        idle(2);
        chk2(timer_out_pin1, timer_out_pin0, 2'h0);
        wr(ix[0], 8'h00);
    endtask
    task t_cap;
        for (int c = 0; c < 4; c++) begin
            cfg(`TIOEC_MD_FREE_RUN, 1'h0);
            wr(ix[1], {4'h0, c[1:0], c[1:0]});
            run(1'h1);
            edges(0, 6, c[0] + c[1], 0, 0, 0);
            edges(1, 11, 0, c[0] + c[1], 0, 0);
        end
        cfg(`TIOEC_MD_INTERVAL, 1'h0);
        run(1'h1);
        edges(0, 6, 0, 0, 0, 0);
        cfg(`TIOEC_MD_PULSE_WID, 1'h0);
        run(1'h1);
        edges(1, 6, 0, 2, 0, 0);
        cfg(`TIOEC_MD_INTERVAL, 1'h0);
        wr(ix[1], 8'h00);
    endtask
    task t_evt;
        for (int c = 0; c < 4; c++) begin
            cfg(`TIOEC_MD_ONE_SHOT, 1'h1);
            wr(ix[2], {4'h0, c[1:0], c[1:0]});
            run(1'h1);
            edges(0, 6, 0, 0, c[0] + c[1], c[0] + c[1]);
        end
        for (int m = 0; m < 7; m++) begin
            cfg(m[2:0], 1'h0);
            run(1'h1);
            edges(0, 6, 0, 0, m == 1 ? 2 : 0, m == 2 || m == 3 ? 2 : 0);
        end
        cfg(`TIOEC_MD_INTERVAL, 1'h1);
        run(1'h1);
        edges(0, 6, 0, 0, 2, 0);
        cfg(`TIOEC_MD_INTERVAL, 1'h0);
    endtask
    task t_ovf;
        cfg(`TIOEC_MD_FREE_RUN, 1'h0);
        run(1'h1);
        b = n_ov;
        strobe(2);
        chk(n_ov - b, 1);
        rd(ix[3], 8'h01);
        rd(ix[3], 8'h01);
        wr(ix[3], 8'h01);
        rd(ix[3], 8'h01);
        wr(ix[3], 8'h00);
        rd(ix[3], 8'h00);
        wr(ix[3], 8'h01);
        rd(ix[3], 8'h00);
        strobe(2);
        run(1'h0);
        idle(2);
        rd(ix[3], 8'h00);
        cfg(`TIOEC_MD_INTERVAL, 1'h0);
        run(1'h1);
        b = n_ov;
        strobe(2);
        chk(n_ov - b, 0);
        rd(ix[3], 8'h00);
    endtask
    task t_ccr;
        cfg(`TIOEC_MD_FREE_RUN, 1'h0);
        wr(ix[3], 8'h30);
        idle(2);
        chk2(ccr1_capture_mode, ccr0_capture_mode, 2'h3);
        wr(ix[3], 8'h10);
        idle(2);
        chk2(ccr1_capture_mode, ccr0_capture_mode, 2'h1);
        cfg(`TIOEC_MD_PULSE_WID, 1'h0);
        idle(2);
        chk2(ccr1_capture_mode, ccr0_capture_mode, 2'h3);
        wr(ix[3], 8'h30);
        cfg(`TIOEC_MD_INTERVAL, 1'h0);
        idle(2);
        chk2(ccr1_capture_mode, ccr0_capture_mode, 2'h0);
    endtask
    task t_rst;
        cfg(`TIOEC_MD_FREE_RUN, 1'h0);
        wr(ix[0], 8'h0A);
        wr(ix[3], 8'h30);
        idle(2);
        chk2(timer_out_pin1, timer_out_pin0, 2'h3);
        chk2(ccr1_capture_mode, ccr0_capture_mode, 2'h3);
        rst <= 1'h1;
        idle(3);
        rst <= 1'h0;
        idle(2);
        chk2(timer_out_pin1, timer_out_pin0, 2'h0);
        chk2(ccr1_capture_mode, ccr0_capture_mode, 2'h0);
        rd(ix[0], 8'h00);
        rd(ix[3], 8'h00);
    endtask
    initial begin
        idle(3);
        rst <= 1'h0;
        t_regs;
        t_out;
        t_cap;
        t_evt;
        t_ovf;
        t_ccr;
        t_rst;
        end_of_test;
    end
endmodule // testbench

// file: tioec_pin_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// driver of the two timer input pins
// ----------------------------------------------------------------
module tioec_pin_model (
    input wire clk_sys,
    output reg timer_in_pin0,
    output reg timer_in_pin1
);
    initial begin
        timer_in_pin0 = 1'h0;
        timer_in_pin1 = 1'h0;
    end
    // one high pulse on a pin, gap sets how slowly it moves
    task pulse(input int pin, input int gap);
        @(posedge clk_sys);
        if (pin == 0) timer_in_pin0 <= 1'h1;
        else timer_in_pin1 <= 1'h1;
        repeat (gap) @(posedge clk_sys);
        timer_in_pin0 <= 1'h0;
        timer_in_pin1 <= 1'h0;
        repeat (gap) @(posedge clk_sys);
    endtask
endmodule // tioec_pin_model

// file: tioec_props.sv
`timescale 1ns/1ps
`include "tioec_regs.vh"
// ----------------------------------------------------------------
// port checker
// ----------------------------------------------------------------
module tioec_props (
    input wire clk_sys,
    input wire rst,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_ack_o,
    input wire timer_run_enable,
    input wire external_event_clock_select,
    input wire [2:0] timer_mode,
    input wire counter_wrap,
    input wire capture0_strobe,
    input wire capture1_strobe,
    input wire event_count_strobe,
    input wire trigger_strobe,
    input wire overflow_interrupt,
    input wire ccr0_capture_mode,
    input wire ccr1_capture_mode
);
    wire run = timer_run_enable;
    wire cap_md = timer_mode == `TIOEC_MD_FREE_RUN || timer_mode == `TIOEC_MD_PULSE_WID;
    wire trg_md = timer_mode == `TIOEC_MD_EXT_TRIG || timer_mode == `TIOEC_MD_ONE_SHOT;
    wire evt_ok = external_event_clock_select || timer_mode == `TIOEC_MD_EVENT;
    wire ovf_cause = run && counter_wrap && cap_md;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack late");
    a_cap0_gate: assert property (capture0_strobe |-> $past(run) && $past(cap_md))
        else $error("capture 0 outside mode");
    a_cap1_gate: assert property (capture1_strobe |-> $past(run) && $past(cap_md))
        else $error("capture 1 outside mode");
    a_evt_gate: assert property (event_count_strobe |-> $past(run) && $past(evt_ok))
        else $error("event outside mode");
    a_trig_gate: assert property (trigger_strobe |-> $past(run) && $past(trg_md))
        else $error("trigger outside mode");
    a_ovf_set: assert property (ovf_cause |=> overflow_interrupt)
        else $error("overflow missed");
    a_ovf_cause: assert property (overflow_interrupt |-> $past(ovf_cause))
        else $error("overflow without wrap");
    a_ccr_pwid: assert property ((timer_mode == `TIOEC_MD_PULSE_WID)[*2] |-> ccr0_capture_mode && ccr1_capture_mode)
        else $error("capture mode not forced");
    a_ccr_gate: assert property (ccr0_capture_mode || ccr1_capture_mode |-> $past(cap_md))
        else $error("capture mode outside mode");
endmodule // tioec_props

bind tioec_top tioec_props u_props (.clk_sys, .rst, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
    .timer_run_enable, .external_event_clock_select, .timer_mode, .counter_wrap,
    .capture0_strobe, .capture1_strobe, .event_count_strobe, .trigger_strobe,
    .overflow_interrupt, .ccr0_capture_mode, .ccr1_capture_mode);

// file: tioec_regs.vh
`ifndef TIOEC_REGS_VH
`define TIOEC_REGS_VH

// ----------------------------------------------------------------
// register indexes (byte address = index * 4)
// ----------------------------------------------------------------
`define TIOEC_IDX_OUT_CTRL 28'hFFFF5A2
`define TIOEC_IDX_CAP_EDGE 28'hFFFF5A3
`define TIOEC_IDX_EVT_TRIG 28'hFFFF5A4
`define TIOEC_IDX_CC_OPT 28'hFFFF5A5

// ----------------------------------------------------------------
// reset values and writable bit masks
// ----------------------------------------------------------------
`define TIOEC_RST_VAL 8'h00
`define TIOEC_MASK_OUT_CTRL 8'h0F
`define TIOEC_MASK_CAP_EDGE 8'h0F
`define TIOEC_MASK_EVT_TRIG 8'h0F
`define TIOEC_MASK_CC_OPT 8'h31

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define TIOEC_OUT0_EN 0
`define TIOEC_OUT0_LVL 1
`define TIOEC_OUT1_EN 2
`define TIOEC_OUT1_LVL 3
`define TIOEC_CAP0_LO 0
`define TIOEC_CAP1_LO 2
`define TIOEC_TRIG_LO 0
`define TIOEC_EVT_LO 2
`define TIOEC_OVF_BIT 0
`define TIOEC_CCS0_BIT 4
`define TIOEC_CCS1_BIT 5

// ----------------------------------------------------------------
// edge select codes
// ----------------------------------------------------------------
`define TIOEC_EDGE_NONE 2'h0
`define TIOEC_EDGE_RISE 2'h1
`define TIOEC_EDGE_FALL 2'h2
`define TIOEC_EDGE_BOTH 2'h3

// ----------------------------------------------------------------
// timer mode codes
// ----------------------------------------------------------------
`define TIOEC_MD_INTERVAL 3'h0
`define TIOEC_MD_EVENT 3'h1
`define TIOEC_MD_EXT_TRIG 3'h2
`define TIOEC_MD_ONE_SHOT 3'h3
`define TIOEC_MD_PWM 3'h4
`define TIOEC_MD_FREE_RUN 3'h5
`define TIOEC_MD_PULSE_WID 3'h6

// ----------------------------------------------------------------
// synchroniser depth
// ----------------------------------------------------------------
`define TIOEC_SYNC_STAGES 2

`endif

// file: tioec_sync.v
`timescale 1ns/1ps

// ----------------------------------------------------------------
// two-stage synchroniser plus one history stage per input
// ----------------------------------------------------------------
module tioec_sync #(
    parameter W = 2
) (
    input wire clk_sys,
    input wire rst,
    input wire [W-1:0] pin_in,
    output reg [W-1:0] cur_r,
    output reg [W-1:0] prev_r
);

reg [W-1:0] meta_r;

always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
        meta_r <= {W{1'h0}};
        cur_r <= {W{1'h0}};
        prev_r <= {W{1'h0}};
    end else begin
        meta_r <= pin_in;
        cur_r <= meta_r;
        prev_r <= cur_r;
    end
end

endmodule // tioec_sync

// file: tioec_top.v
`timescale 1ns/1ps
`include "tioec_regs.vh"

// Function
// [R1] four 8-bit control registers, byte or bit access, reset to zero
// [R2] output-1 level bit 0 starts pin 1 high, 1 starts it low
// [R3] output-1 disabled: pin 1 static, equal to its level bit
// [R4] output-1 enabled: timer square wave drives pin 1
// [R5] output-0 level bit 0 starts pin 0 high, 1 starts it low
// [R6] output-0 disabled: pin 0 static, equal to its level bit
// [R7] output-0 enabled: timer square wave drives pin 0
// [R8] software changes output bits only while timer stopped
// [R9] timer stopped and output disabled: level bit drives pin directly
// [R10] capture-1 edge field picks none, rising, falling or both on input 1
// [R11] capture-0 edge field picks none, rising, falling or both on input 0
// [R12] capture only in free-running and pulse width modes
// [R13] software changes capture edge fields only while timer stopped
// [R14] event edge field picks counted edge on input 0
// [R15] trigger edge field picks trigger edge on input 0
// [R16] event edge honoured only with event clock select or event mode
// [R17] trigger edge honoured only in trigger pulse or one-shot modes
// [R18] software changes event and trigger fields only while timer stopped
// [R19] option holds capture selects at bits 5, 4 and overflow at bit 0
// [R20] select 1 means capture register, valid only in free-running mode
// [R21] wrap in free-running or pulse width mode sets flag and interrupt
// [R22] overflow flag clears on software write 0 or timer stopped
// [R23] enabled output toggles on every compare match of its channel
// [R24] unused register bits read zero and ignore writes
module tioec_top (
    input wire clk_sys,
    input wire rst,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [31:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    input wire timer_run_enable,
    input wire external_event_clock_select,
    input wire [2:0] timer_mode,
    input wire compare_match0,
    input wire compare_match1,
    input wire counter_wrap,
    input wire timer_in_pin0,
    input wire timer_in_pin1,
    output reg timer_out_pin0,
    output reg timer_out_pin1,
    output reg capture0_strobe,
    output reg capture1_strobe,
    output reg event_count_strobe,
    output reg trigger_strobe,
    output reg overflow_interrupt,
    output reg ccr0_capture_mode,
    output reg ccr1_capture_mode
);

// ----------------------------------------------------------------
// edge decode
// ----------------------------------------------------------------
function edge_hit;
    input [1:0] sel;
    input prev;
    input cur;
    begin
        case (sel)
            `TIOEC_EDGE_RISE: edge_hit = ~prev & cur;
            `TIOEC_EDGE_FALL: edge_hit = prev & ~cur;
            `TIOEC_EDGE_BOTH: edge_hit = prev ^ cur;
            default: edge_hit = 1'h0;
        endcase
    end
endfunction

// ----------------------------------------------------------------
// register state
// ----------------------------------------------------------------
reg [7:0] timer_output_control_r;
reg [7:0] capture_edge_select_r;
reg [7:0] event_trigger_edge_select_r;
reg [5:4] cc_select_r;
reg counter_overflow_flag_r;
reg counter_overflow_flag_nxt;

wire [1:0] pin_cur;
wire [1:0] pin_prev;

// ----------------------------------------------------------------
// input pin synchroniser
// ----------------------------------------------------------------
tioec_sync #(
    .W(2)
) u_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .pin_in({timer_in_pin1, timer_in_pin0}),
    .cur_r(pin_cur),
    .prev_r(pin_prev)
);

// ----------------------------------------------------------------
// bus decode
// ----------------------------------------------------------------
wire bus_req;
wire bus_wr;
wire lane0_wr;
wire [27:0] reg_idx;
wire adr_hi_ok;
wire hit_out;
wire hit_cap;
wire hit_evt;
wire hit_opt;
wire [7:0] wr_byte;

assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
assign bus_wr = bus_req & wb_we_i;
assign lane0_wr = bus_wr & wb_sel_i[0];
assign reg_idx = wb_adr_i[29:2];
assign adr_hi_ok = (wb_adr_i[31:30] == 2'h0) && (wb_adr_i[1:0] == 2'h0);
assign hit_out = adr_hi_ok && (reg_idx == `TIOEC_IDX_OUT_CTRL);
assign hit_cap = adr_hi_ok && (reg_idx == `TIOEC_IDX_CAP_EDGE);
assign hit_evt = adr_hi_ok && (reg_idx == `TIOEC_IDX_EVT_TRIG);
assign hit_opt = adr_hi_ok && (reg_idx == `TIOEC_IDX_CC_OPT);
assign wr_byte = wb_dat_i[7:0];

// ----------------------------------------------------------------
// control registers
// ----------------------------------------------------------------
always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
        timer_output_control_r <= `TIOEC_RST_VAL; // R1
        capture_edge_select_r <= `TIOEC_RST_VAL; // R1
        event_trigger_edge_select_r <= `TIOEC_RST_VAL; // R1
        cc_select_r <= 2'h0; // R1
    end else if (lane0_wr) begin
        if (hit_out) begin
            timer_output_control_r <= wr_byte & `TIOEC_MASK_OUT_CTRL; // R24
        end
        if (hit_cap) begin
            capture_edge_select_r <= wr_byte & `TIOEC_MASK_CAP_EDGE; // R24
        end
        if (hit_evt) begin
            event_trigger_edge_select_r <= wr_byte & `TIOEC_MASK_EVT_TRIG; // R24
        end
        if (hit_opt) begin
            cc_select_r <= wr_byte[`TIOEC_CCS1_BIT:`TIOEC_CCS0_BIT]; // R19
        end
    end
end

// ----------------------------------------------------------------
// mode qualifiers
// ----------------------------------------------------------------
wire run;
wire md_free;
wire md_pw;
wire cap_ok;
wire evt_ok;
wire trig_ok;

assign run = timer_run_enable;
assign md_free = (timer_mode == `TIOEC_MD_FREE_RUN);
assign md_pw = (timer_mode == `TIOEC_MD_PULSE_WID);
assign cap_ok = run & (md_free | md_pw); // R12
assign evt_ok = run & (external_event_clock_select |
                       (timer_mode == `TIOEC_MD_EVENT)); // R16
assign trig_ok = run & ((timer_mode == `TIOEC_MD_EXT_TRIG) |
                        (timer_mode == `TIOEC_MD_ONE_SHOT)); // R17

// ----------------------------------------------------------------
// field views
// ----------------------------------------------------------------
wire [1:0] cap0_sel;
wire [1:0] cap1_sel;
wire [1:0] evt_sel;
wire [1:0] trig_sel;
wire out0_en;
wire out0_lvl;
wire out1_en;
wire out1_lvl;

assign cap0_sel = capture_edge_select_r[`TIOEC_CAP0_LO+1:`TIOEC_CAP0_LO];
assign cap1_sel = capture_edge_select_r[`TIOEC_CAP1_LO+1:`TIOEC_CAP1_LO];
assign trig_sel = event_trigger_edge_select_r[`TIOEC_TRIG_LO+1:`TIOEC_TRIG_LO];
assign evt_sel = event_trigger_edge_select_r[`TIOEC_EVT_LO+1:`TIOEC_EVT_LO];
assign out0_en = timer_output_control_r[`TIOEC_OUT0_EN];
assign out0_lvl = timer_output_control_r[`TIOEC_OUT0_LVL];
assign out1_en = timer_output_control_r[`TIOEC_OUT1_EN];
assign out1_lvl = timer_output_control_r[`TIOEC_OUT1_LVL];

// ----------------------------------------------------------------
// edge strobes
// ----------------------------------------------------------------
always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
        capture0_strobe <= 1'h0;
        capture1_strobe <= 1'h0;
        event_count_strobe <= 1'h0;
        trigger_strobe <= 1'h0;
    end else begin
        capture0_strobe <= cap_ok & edge_hit(cap0_sel, pin_prev[0], pin_cur[0]); // R11
        capture1_strobe <= cap_ok & edge_hit(cap1_sel, pin_prev[1], pin_cur[1]); // R10
        event_count_strobe <= evt_ok & edge_hit(evt_sel, pin_prev[0], pin_cur[0]); // R14
        trigger_strobe <= trig_ok & edge_hit(trig_sel, pin_prev[0], pin_cur[0]); // R15
    end
end

// ----------------------------------------------------------------
// capture role decode
// ----------------------------------------------------------------
function ccr_role;
    input [2:0] mode;
    input sel;
    begin
        case (mode)
            `TIOEC_MD_PULSE_WID: ccr_role = 1'h1;
            `TIOEC_MD_FREE_RUN: ccr_role = sel;
            default: ccr_role = 1'h0;
        endcase
    end
endfunction

// ----------------------------------------------------------------
// capture or compare role per register
// ----------------------------------------------------------------
always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
        ccr0_capture_mode <= 1'h0;
        ccr1_capture_mode <= 1'h0;
    end else begin
        ccr0_capture_mode <= ccr_role(timer_mode, cc_select_r[`TIOEC_CCS0_BIT]); // R19 R20
        ccr1_capture_mode <= ccr_role(timer_mode, cc_select_r[`TIOEC_CCS1_BIT]); // R19 R20
    end
end

// ----------------------------------------------------------------
// overflow flag
// ----------------------------------------------------------------
wire ovf_set;
wire ovf_sw_clr;

assign ovf_set = run & counter_wrap & (md_free | md_pw); // R21
assign ovf_sw_clr = lane0_wr & hit_opt & ~wr_byte[`TIOEC_OVF_BIT]; // R22

always @* begin
    counter_overflow_flag_nxt = counter_overflow_flag_r;
    if (!run) begin
        counter_overflow_flag_nxt = 1'h0; // R22
    end else if (ovf_set) begin
        counter_overflow_flag_nxt = 1'h1; // R21
    end else if (ovf_sw_clr) begin
        counter_overflow_flag_nxt = 1'h0; // R22
    end
end

always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
        counter_overflow_flag_r <= 1'h0;
        overflow_interrupt <= 1'h0;
    end else begin
        counter_overflow_flag_r <= counter_overflow_flag_nxt;
        overflow_interrupt <= ovf_set; // R21
    end
end

// ----------------------------------------------------------------
// timer output pins
// ----------------------------------------------------------------
// static when disabled, start level while stopped, toggles while running
function pin_level;
    input en;
    input lvl;
    input running;
    input match;
    input cur;
    begin
        if (!en) begin
            pin_level = lvl; // R3 R6 R9
        end else if (!running) begin
            pin_level = ~lvl; // R2 R5
        end else if (match) begin
            pin_level = ~cur; // R23
        end else begin
            pin_level = cur; // R4 R7
        end
    end
endfunction

reg out0_nxt;
reg out1_nxt;

always @* begin
    out0_nxt = pin_level(out0_en, out0_lvl, run, compare_match0, timer_out_pin0); // R5 R7 R23
end

always @* begin
    out1_nxt = pin_level(out1_en, out1_lvl, run, compare_match1, timer_out_pin1); // R2 R4 R23
end

always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
        timer_out_pin0 <= 1'h0;
        timer_out_pin1 <= 1'h0;
    end else begin
        timer_out_pin0 <= out0_nxt;
        timer_out_pin1 <= out1_nxt;
    end
end

// ----------------------------------------------------------------
// read mux
// ----------------------------------------------------------------
reg [7:0] rd_byte;

always @* begin
    rd_byte = 8'h00;
    if (hit_out) begin
        rd_byte = timer_output_control_r;
    end else if (hit_cap) begin
        rd_byte = capture_edge_select_r;
    end else if (hit_evt) begin
        rd_byte = event_trigger_edge_select_r;
    end else if (hit_opt) begin
        rd_byte = {2'h0, cc_select_r, 3'h0, counter_overflow_flag_r}; // R19 R24
    end
end

// ----------------------------------------------------------------
// wishbone answer
// ----------------------------------------------------------------
always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
        wb_ack_o <= 1'b0;
        wb_dat_o <= 32'h00000000;
    end else begin
        wb_ack_o <= bus_req;
        if (bus_req && !wb_we_i) begin
            wb_dat_o <= {24'h000000, rd_byte};
        end
    end
end

endmodule // tioec_top
